// >>> sdd_gain_filter.sv
// How it works
// - Input sample rate doubles per gain, caps at eight.
// - Gains one to eight by repeated input sampling.
// - Gains sixteen to 128 made digitally after filter.
// - Polarity bit never changes input sampling.
// - Bit 4 drives burn-out source, off after reset.
// - Datapath saturates instead of wrapping on overrange.
// - Modulator bit taken every 128 master clocks.
// - Each modulator bit widened to a 40-bit word.
// - Third-order integrator-comb decimator, no multipliers.
// - Decimation set by 11-bit notch code.
// - One output word per notch period.
// - Step settles within three to four periods.
// - Response shape independent of clock and code.
// - Bipolar zero input reads 800000 hex in offset binary, 000000 in two's complement.
// - Bipolar offset or two's complement, unipolar binary.
// - Writing upper control bytes resynchronises and clears ready.
// - Ready asserts after three periods from resync.
//
// Our own choices: the register offsets and register access over Avalon-MM.
module sdd_gain_filter
   import sdd_pkg::*;
#(
   parameter int unsigned ACC_W = ACC_W_DEF
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire sdd_avs_req_t avs_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic mod_bit_i,
   output logic input_sample_o,
   output logic [1:0] input_gain_amplifier_o,
   output logic burnout_source_enable_o,
   output logic result_valid_n_o
);
   typedef enum logic {PH_SETTLE, PH_RUN} sdd_phase_t;

   typedef struct packed {
      sdd_ctrl_t ctrl;
      logic [1:0] mod_sync;
      logic [6:0] mod_div;
      logic [6:0] smp_div;
      logic [2:0][ACC_W-1:0] integ;
      logic [2:0][ACC_W-1:0] dly;
      logic [12:0] dec_cnt;
      logic [1:0] words;
      sdd_phase_t phase;
      logic [23:0] data;
      logic valid_n;
      logic waitreq;
      logic [31:0] rdata;
      logic isamp;
      logic [1:0] gsel;
      logic bo;
   } sdd_state_t;

   localparam sdd_state_t ST_RST = '{ctrl: CTRL_RST, valid_n: 1'b1, waitreq: 1'b1,
                                    phase: PH_SETTLE, default: '0};

   sdd_state_t st_r;
   sdd_state_t st_nxt;

   function automatic logic [3:0] sdd_clog2(input logic [12:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 13; i++) begin
         if ((13'h0001 << i) < v) begin
            n = 4'(i + 1);
         end
      end
      return n;
   endfunction

   logic mod_tick;
   logic dec_evt;
   logic acc_done;
   logic wr_ctrl;
   logic resync;
   logic rd_data;
   logic [1:0] fe_gain;
   logic [3:0] dig_gain;
   logic [6:0] smp_period;
   logic [ACC_W-1:0] x_word;
   logic [ACC_W-1:0] n0;
   logic [ACC_W-1:0] n1;
   logic [ACC_W-1:0] n2;
   logic [ACC_W-1:0] c1;
   logic [ACC_W-1:0] c2;
   logic [ACC_W-1:0] c3;
   logic [12:0] ratio;
   logic [5:0] shift;
   logic signed [63:0] wide;
   logic signed [ACC_W-1:0] sat;
   logic [23:0] res24;
   logic [23:0] coded;

   always_comb begin
      st_nxt = st_r;
      // Bipolar and coding bits are not looked at here by design.
      fe_gain = (st_r.ctrl.gain > 3'(FE_GAIN_MAX)) ? 2'(FE_GAIN_MAX) : st_r.ctrl.gain[1:0];
      dig_gain = (st_r.ctrl.gain > 3'(FE_GAIN_MAX)) ? 4'(st_r.ctrl.gain - 3'(FE_GAIN_MAX)) : 4'h0;
      smp_period = 7'((MOD_DIV >> fe_gain) - 1);
      mod_tick = (st_r.mod_div == 7'h00);
      ratio = 13'({st_r.ctrl.notch_code, DEC_SHIFT'(0)});
      dec_evt = mod_tick && (st_r.dec_cnt == 13'h0000);

      acc_done = !st_r.waitreq;
      wr_ctrl = acc_done && avs_i.write && (avs_i.address == REG_CTRL);
      resync = wr_ctrl && (avs_i.byteenable[2] || avs_i.byteenable[1]);
      rd_data = acc_done && avs_i.read && (avs_i.address == REG_DATA);

      // Synchroniser for the modulator bit; the second stage alone is used.
      st_nxt.mod_sync = {st_r.mod_sync[0], mod_bit_i};
      st_nxt.mod_div = mod_tick ? 7'(MOD_DIV - 1) : 7'(st_r.mod_div - 7'h01);
      st_nxt.isamp = (st_r.smp_div == 7'h00);
      st_nxt.smp_div = (st_r.smp_div == 7'h00 || st_r.smp_div > smp_period) ?
                       smp_period : 7'(st_r.smp_div - 7'h01);
      st_nxt.gsel = fe_gain;
      st_nxt.bo = st_r.ctrl.burnout;

      // One modulator bit becomes +1 or -1 at full accumulator width.
      x_word = {{(ACC_W-1){~st_r.mod_sync[1]}}, 1'b1};
      n0 = st_r.integ[0] + x_word;
      n1 = st_r.integ[1] + n0;
      n2 = st_r.integ[2] + n1;
      c1 = n2 - st_r.dly[0];
      c2 = c1 - st_r.dly[1];
      c3 = c2 - st_r.dly[2];
      // Gain of the filter is ratio cubed; a shift divides by ratio rounded up to a power of two,
      // cubed, so the level stays the same across codes only where ratio is a power of two.
      shift = 6'(ACC_W - 1 - 3 * sdd_clog2(ratio)) + 6'(dig_gain);
      wide = 64'($signed(c3)) <<< shift;
      // Modular integrators are exact; only the scaled result can overflow.
      if (wide > 64'($signed({1'b0, {(ACC_W-1){1'b1}}}))) begin
         sat = {1'b0, {(ACC_W-1){1'b1}}};
      end else if (wide < 64'($signed({1'b1, {(ACC_W-1){1'b0}}}))) begin
         sat = {1'b1, {(ACC_W-1){1'b0}}};
      end else begin
         sat = ACC_W'(wide);
      end
      res24 = sat[ACC_W-1 -: 24];
      if (!st_r.ctrl.bipolar) begin
         coded = res24[23] ? 24'h000000 : {res24[22:0], 1'b0};
      end else if (st_r.ctrl.twos) begin
         coded = res24;
      end else begin
         coded = res24 ^ MIDSCALE;
      end

      if (mod_tick) begin
         st_nxt.integ = {n2, n1, n0};
         st_nxt.dec_cnt = dec_evt ? 13'(ratio - 13'h0001) : 13'(st_r.dec_cnt - 13'h0001);
      end
      if (dec_evt) begin
         st_nxt.dly = {c2, c1, n2};
         if (st_r.phase == PH_SETTLE) begin
            st_nxt.words = 2'(st_r.words + 2'h1);
            if (st_r.words == 2'(SETTLE_WORDS - 1)) begin
               st_nxt.phase = PH_RUN;
            end
         end
      end

      // A read of the result raises ready; a new word in the same cycle wins.
      if (rd_data) begin
         st_nxt.valid_n = 1'b1;
      end
      if (dec_evt && (st_r.phase == PH_RUN || st_r.words == 2'(SETTLE_WORDS - 1))) begin
         st_nxt.data = coded;
         st_nxt.valid_n = 1'b0;
      end

      if (wr_ctrl) begin
         for (int b = 0; b < 3; b++) begin
            if (avs_i.byteenable[b]) begin
               st_nxt.ctrl[8*b +: 8] = avs_i.writedata[8*b +: 8];
            end
         end
      end
      if (resync) begin
         st_nxt.integ = '0;
         st_nxt.dly = '0;
         st_nxt.mod_div = 7'(MOD_DIV - 1);
         // A full ratio of ticks must pass before the first word is counted, or the
         // third word would arrive before three whole periods of input had been seen.
         st_nxt.dec_cnt = 13'({st_nxt.ctrl.notch_code, DEC_SHIFT'(0)}) - 13'h0001;
         st_nxt.words = 2'h0;
         st_nxt.phase = PH_SETTLE;
         st_nxt.valid_n = 1'b1;
      end

      // One wait cycle per access; unmapped reads return zero.
      st_nxt.waitreq = !((avs_i.read || avs_i.write) && st_r.waitreq);
      st_nxt.rdata = 32'h00000000;
      if (avs_i.read && st_r.waitreq) begin
         case (avs_i.address)
            REG_CTRL: st_nxt.rdata = {8'h00, st_r.ctrl};
            REG_STAT: st_nxt.rdata = {30'h0, st_r.phase == PH_RUN, ~st_r.valid_n};
            REG_DATA: st_nxt.rdata = {8'h00, st_r.data};
            default: st_nxt.rdata = 32'h00000000;
         endcase
      end else if (!st_r.waitreq) begin
         st_nxt.rdata = st_r.rdata;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign avs_readdata_o = st_r.rdata;
   assign avs_waitrequest_o = st_r.waitreq;
   assign input_sample_o = st_r.isamp;
   assign input_gain_amplifier_o = st_r.gsel;
   assign burnout_source_enable_o = st_r.bo;
   assign result_valid_n_o = st_r.valid_n;

   // All checks share the master clock and are quiet while reset is held.
   // Bus-side checks only look at what the block answers, never at the request alone.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_fast_sampling;
      input_sample_o && st_r.ctrl.gain >= 3'h3 |=> !input_sample_o [*8] ##8 input_sample_o;
   endproperty
   a_fast_sampling: assert property (p_fast_sampling) else $error("gain 8 sample spacing wrong");

   property p_fe_gain;
      ##1 input_gain_amplifier_o == (($past(st_r.ctrl.gain) > 3'h3) ? 2'h3 : $past(st_r.ctrl.gain[1:0]));
   endproperty
   a_fe_gain: assert property (p_fe_gain) else $error("front gain select wrong");

   property p_burnout;
      ##1 burnout_source_enable_o == $past(st_r.ctrl.burnout);
   endproperty
   a_burnout: assert property (p_burnout) else $error("burn-out enable mismatch");

   property p_mod_tick;
      mod_tick |=> !mod_tick [*8];
   endproperty
   a_mod_tick: assert property (p_mod_tick) else $error("modulator tick too soon");

   property p_resync;
      resync |=> result_valid_n_o && st_r.phase == PH_SETTLE && st_r.words == 2'h0;
   endproperty
   a_resync: assert property (p_resync) else $error("resync did not clear ready");

   property p_ready_after_settle;
      $fell(result_valid_n_o) |-> st_r.phase == PH_RUN && $past(dec_evt);
   endproperty
   a_ready_after_settle: assert property (p_ready_after_settle) else $error("ready too early");

   property p_midscale;
      dec_evt && c3 == '0 && st_r.ctrl.bipolar && !st_r.ctrl.twos && st_r.phase == PH_RUN
         |=> st_r.data == MIDSCALE;
   endproperty
   a_midscale: assert property (p_midscale) else $error("zero input not midscale");

   property p_dec_spacing;
      dec_evt |=> !dec_evt [*8];
   endproperty
   a_dec_spacing: assert property (p_dec_spacing) else $error("decimation too fast");

   property p_wait_one;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low twice");

   property p_unipolar;
      dec_evt && !st_r.ctrl.bipolar && $signed(res24) < 0 |=> st_r.data == 24'h000000 || st_r.phase == PH_SETTLE;
   endproperty
   a_unipolar: assert property (p_unipolar) else $error("unipolar negative not zero");

   property p_isamp_pulse;
      input_sample_o |=> !input_sample_o;
   endproperty
   a_isamp_pulse: assert property (p_isamp_pulse) else $error("sample strobe too long");

   property p_wait_answer;
      (avs_i.read || avs_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("bus access not answered");

   property p_waitreq_idle;
      !avs_i.read && !avs_i.write && avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_waitreq_idle: assert property (p_waitreq_idle) else $error("answer without request");

   // The resync must reload a whole notch period and empty the integrators.
   property p_resync_load;
      resync |=> st_r.dec_cnt == {st_r.ctrl.notch_code, 2'b00} - 13'h0001 && st_r.integ == '0;
   endproperty
   a_resync_load: assert property (p_resync_load) else $error("resync load wrong");

   property p_dec_load;
      dec_evt && !resync |=> st_r.dec_cnt == {$past(st_r.ctrl.notch_code), 2'b00} - 13'h0001;
   endproperty
   a_dec_load: assert property (p_dec_load) else $error("decimation count wrong");

   property p_read_clears;
      rd_data && !dec_evt |=> result_valid_n_o;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read left ready low");

   // Ready stays low until the word is read or the filter is resynchronised.
   property p_ready_hold;
      !result_valid_n_o && !rd_data && !resync |=> !result_valid_n_o;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready dropped unread");

   property p_new_word;
      dec_evt && st_r.phase == PH_RUN && !resync |=> !result_valid_n_o;
   endproperty
   a_new_word: assert property (p_new_word) else $error("new word not flagged");

   // Early words after a resync are not settled and must stay hidden.
   property p_settle_count;
      dec_evt && st_r.phase == PH_SETTLE && st_r.words < 2'(SETTLE_WORDS - 1) && !resync
         |=> result_valid_n_o;
   endproperty
   a_settle_count: assert property (p_settle_count) else $error("unsettled word shown");

   property p_run_sticky;
      st_r.phase == PH_RUN && !resync |=> st_r.phase == PH_RUN;
   endproperty
   a_run_sticky: assert property (p_run_sticky) else $error("left run phase");

   property p_data_hold;
      !dec_evt |=> $stable(st_r.data);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("result changed between words");

   c_resync: cover property (resync);
   c_ready: cover property ($fell(result_valid_n_o));
   c_read_data: cover property (rd_data && !result_valid_n_o);
   c_saturate: cover property (dec_evt && sat != ACC_W'(wide));
   c_unipolar: cover property (dec_evt && !st_r.ctrl.bipolar && st_r.phase == PH_RUN);
endmodule

// >>> sdd_pkg.sv
package sdd_pkg;
   // Modulator bit rate is the master clock divided by this.
   localparam int unsigned MOD_DIV = 128;
   // Notch period in master clocks is this times the notch code.
   localparam int unsigned NOTCH_MUL = 512;
   localparam int unsigned DEC_SHIFT = $clog2(NOTCH_MUL / MOD_DIV);
   localparam int unsigned ACC_W_DEF = 40;
   localparam int unsigned SETTLE_WORDS = 3;
   localparam int unsigned FE_GAIN_MAX = 3;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [23:0] CTRL_RST = 24'h028b08;
   localparam logic [23:0] MIDSCALE = 24'h800000;
   localparam logic [10:0] CODE_MIN = 11'h00a;

   typedef struct packed {
      logic [4:0] rsv_hi;
      logic [10:0] notch_code;
      logic [1:0] rsv_lo;
      logic twos;
      logic burnout;
      logic bipolar;
      logic [2:0] gain;
   } sdd_ctrl_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } sdd_avs_req_t;
endpackage

// >>> sdd_mod_model.sv
module sdd_mod_model (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] level_i,
   output logic mod_bit_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] tick_r;
   logic [8:0] acc_r;
   // A first-order loop keeps the ones density at level_i/256, so a short period divides 40.
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         tick_r <= 7'h00;
         acc_r <= 9'h000;
         mod_bit_o <= 1'b0;
      end else begin
         tick_r <= tick_r + 7'h01;
         if (tick_r == 7'h7f) begin
            acc_r <= {1'b0, acc_r[7:0]} + {1'b0, level_i};
            mod_bit_o <= acc_r[8];
         end
      end
   end
endmodule

// >>> sdd_gain_filter_tb.sv
module sdd_gain_filter_tb
   import sdd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PER = NOTCH_MUL * 10;
   typedef struct packed {logic [2:0] g; logic [1:0] amp; logic [7:0] per;} sdd_row_t;
   sdd_row_t rows [8] = '{'{3'h0, 2'h0, 8'h80}, '{3'h1, 2'h1, 8'h40}, '{3'h2, 2'h2, 8'h20},
      '{3'h3, 2'h3, 8'h10}, '{3'h4, 2'h3, 8'h10}, '{3'h5, 2'h3, 8'h10},
      '{3'h6, 2'h3, 8'h10}, '{3'h7, 2'h3, 8'h10}};
   logic clock_i, sys_rst_i, wreq, smp, bo, valid_n, mbit;
   logic [1:0] amp;
   logic [7:0] level;
   logic [31:0] rdata, d1;
   sdd_avs_req_t avs;
   int err_total, tests_run, cyc, c;
   time t0;
   logic [31:0] rdata_w;
   sdd_gain_filter #(.ACC_W(ACC_W_DEF)) sdd_gain_filter_inst (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .avs_i(avs), .avs_readdata_o(rdata_w),
      .avs_waitrequest_o(wreq), .mod_bit_i(mbit), .input_sample_o(smp),
      .input_gain_amplifier_o(amp), .burnout_source_enable_o(bo), .result_valid_n_o(valid_n));
   sdd_mod_model sdd_mod_model_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .level_i(level), .mod_bit_o(mbit));
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic done(input string s);
      $display("test %s finished, %0d compares, %0d mismatches", s, tests_run, err_total);
   endtask
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] wd,
      input logic [3:0] be);
      @(posedge clock_i);
      avs <= '{read: rd, write: !rd, address: a, writedata: wd, byteenable: be};
      do @(posedge clock_i); while (wreq !== 1'b0);
      rdata = rdata_w;
      avs <= '0;
   endtask
   task automatic wait_on(input logic pol, output int n);
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while ((pol ? smp : valid_n) !== pol);
   endtask
   task automatic rd_word();
      int n;
      wait_on(1'b0, n);
      bus(1'b1, REG_DATA, 32'h0, 4'hf);
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      avs = '0;
      sys_rst_i = 1'b1;
      level = 8'h80;
      repeat (10) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      bus(1'b1, REG_CTRL, 32'h0, 4'hf);
      chk(rdata, {8'h00, CTRL_RST});
      chk({bo, valid_n}, 2'b01);
      bus(1'b1, 4'hc, 32'h0, 4'hf);
      chk(rdata, 32'h0);
      done("reset");
      foreach (rows[i]) begin
         bus(1'b0, REG_CTRL, {29'h0, rows[i].g} | 32'h08, 4'h1);
         wait_on(1'b1, c);
         wait_on(1'b1, c);
         chk(32'(c), 32'(rows[i].per));
         chk(32'(amp), 32'(rows[i].amp));
      end
      bus(1'b0, REG_CTRL, 32'h18, 4'h1);
      repeat (2) @(posedge clock_i);
      chk(32'(bo), 32'h1);
      done("gain table");
      // Notch code 10 is the fastest legal rate and keeps the run short.
      bus(1'b0, REG_CTRL, 32'h000a08, 4'h7);
      repeat (2) @(posedge clock_i);
      chk(32'({bo, valid_n}), 32'h1);
      wait_on(1'b0, c);
      t0 = $time;
      chk(32'(c >= 3 * PER - 8 && c <= 3 * PER + 2 * MOD_DIV), 32'h1);
      bus(1'b1, REG_STAT, 32'h0, 4'hf);
      chk(rdata, 32'h3);
      bus(1'b1, REG_DATA, 32'h0, 4'hf);
      chk(rdata, {8'h00, MIDSCALE});
      repeat (2) @(posedge clock_i);
      chk(32'(valid_n), 32'h1);
      wait_on(1'b0, c);
      chk(32'(($time - t0) / 8), PER);
      done("conversion");
      bus(1'b0, REG_CTRL, 32'h28, 4'h1);
      rd_word();
      rd_word();
      chk(rdata, 32'h0);
      bus(1'b0, REG_CTRL, 32'h00, 4'h1);
      wait_on(1'b1, c);
      wait_on(1'b1, c);
      chk(32'(c), 32'h80);
      rd_word();
      rd_word();
      chk(rdata, 32'h0);
      done("coding");
      level <= 8'ha0;
      bus(1'b0, REG_CTRL, 32'h000a08, 4'h7);
      rd_word();
      d1 = rdata;
      bus(1'b0, REG_CTRL, 32'h0c, 4'h1);
      rd_word();
      rd_word();
      chk(32'(d1 > {8'h00, MIDSCALE}), 32'h1);
      chk(rdata - {8'h00, MIDSCALE}, 2 * (d1 - {8'h00, MIDSCALE}));
      done("digital gain");
      end_sim();
   end
endmodule
